// File: channel_output_polarity_tb.sv
// self-checking bench for the polarity block
// assumes cop_top, cop_load and the checker bind
`timescale 1ns/1ps
module channel_output_polarity_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fault_in = 0;
	logic pready, pslverr, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hF;
	logic [7:0] raw_active = 8'h00, chan_out, load_lvl;
	int n_errors = 0, samples_checked = 0, cyc = 0;
	cop_top i_dut(.*);
	cop_load i_load(.*);
	initial forever #4 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			complete_run;
		end
	end
	task complete_run;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(string nm, logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task apb(logic w, logic [11:0] a, logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task t_reset;
		apb(0, 12'h070, 0);
		chk("pol reset", 0, rd);
		apb(0, 12'h074, 0);
		chk("guard on", 1, rd[6]);
	endtask
	task t_locked;
		apb(1, 12'h070, 32'h000000FF);
		chk("locked err", 0, err);
		apb(0, 12'h070, 0);
		chk("locked pol", 0, rd);
		apb(0, 12'h100, 0);
		chk("unmapped", 1, err);
	endtask
	task t_unlock;
		apb(0, 12'h074, 0);
		apb(1, 12'h054, 32'h4);
		apb(0, 12'h054, 0);
		chk("guard off bit", 1, rd[2]);
		apb(0, 12'h074, 0);
		chk("guard off", 0, rd[6]);
		apb(1, 12'h070, 32'hFFFFFFA5);
		apb(0, 12'h070, 0);
		chk("pol bits", 32'hA5, rd);
	endtask
	task t_levels;
		raw_active <= 8'h0F;
		repeat (3) @(posedge pclk);
		chk("levels", 8'h0F ^ 8'hA5, load_lvl);
	endtask
	task t_fault;
		apb(1, 12'h054, 32'h5);
		fault_in <= 1;
		raw_active <= 8'hF0;
		repeat (8) @(posedge pclk);
		chk("safe level", 8'hA5, load_lvl);
		apb(0, 12'h074, 0);
		chk("fault status", 3'h5, rd[7:5]);
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1;
		t_reset;
		t_locked;
		t_unlock;
		t_levels;
		t_fault;
		presetn <= 0;
		fault_in <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		t_reset;
		complete_run;
	end
endmodule

// File: cop_chan_out.sv
// one channel output stage: polarity and safe level, registered
// assumes raw waveform and controls are on pclk
`timescale 1ns/1ps
`include "cop_consts.svh"

module cop_chan_out
	import cop_pkg::*;
(
	input wire logic pclk, // bus clock
	input wire logic presetn, // async reset, active low
	input wire logic raw_active, // raw waveform, 1 means active
	input wire logic pol, // channel polarity bit
	input wire logic safe, // fault safe state requested
	output logic chan_out // channel output level
);

	cop_chan_state_t st_ff;
	cop_chan_state_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (safe) begin
			nxt_st.chan_out = pol;
		end else begin
			nxt_st.chan_out = raw_active ^ pol;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '{chan_out: `COP_CHAN_OUT_RESET};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign chan_out = st_ff.chan_out;

endmodule

// File: cop_consts.svh
// register offsets, field positions and reset values of the polarity block
// assumes a 12-bit byte address on the APB side
`ifndef COP_CONSTS_SVH
`define COP_CONSTS_SVH

// ***********************************
// register offsets (byte addresses)
// ***********************************
`define COP_MODE_OFFSET 12'h054
`define COP_POL_OFFSET 12'h070
`define COP_STAT_OFFSET 12'h074

// ***********************************
// field positions
// ***********************************
`define COP_MODE_FLT_EN_BIT 0
`define COP_MODE_GUARD_OFF_BIT 2
`define COP_STAT_FLT_IN_BIT 5
`define COP_STAT_GUARD_ON_BIT 6
`define COP_STAT_FLT_FLAG_BIT 7

// ***********************************
// reset values
// ***********************************
`define COP_POL_RESET 8'h00
`define COP_GUARD_OFF_RESET 1'h0
`define COP_FLT_EN_RESET 1'h0
`define COP_CHAN_OUT_RESET 1'h0

`endif

// File: cop_load.sv
// model of the loads on the channel pins
// assumes pins driven by cop_top on pclk
`timescale 1ns/1ps
module cop_load(
	input wire logic pclk, // bus clock
	input wire logic [7:0] chan_out, // channel pins
	output logic [7:0] load_lvl // level seen at each load
);
	always_ff @(posedge pclk) load_lvl <= chan_out;
endmodule

// File: cop_pkg.sv
// types shared by the polarity block
// assumes nothing beyond the constants header
package cop_pkg;

	localparam int COP_CHANNELS = 8;

	typedef logic [COP_CHANNELS-1:0] cop_chan_vec_t;

	typedef struct packed {
		logic chan_out;
	} cop_chan_state_t;

	typedef struct packed {
		cop_chan_vec_t pol;
		logic guard_off;
		logic flt_en;
		logic flt_flag;
		logic armed;
		logic flt_sync1;
		logic flt_sync2;
		logic [31:0] prdata;
	} cop_top_state_t;

endpackage

// File: cop_props.sv
// assertion checker for the polarity block
// assumes only the ports of cop_top
`timescale 1ns/1ps
module cop_props(
	input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fault_in,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic [3:0] pstrb,
	input wire logic [7:0] raw_active, chan_out
);
	logic en_ff, g_ff, v_ff;
	wire acc = psel && penable;
	wire rd_acc = acc && !pwrite;
	wire map = paddr == 12'h054 || paddr == 12'h070 || paddr == 12'h074;
	// shadow of fault enable and of the last guard_off read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_ff <= 1'h0;
			g_ff <= 1'h0;
			v_ff <= 1'h0;
		end else if (acc && pwrite) begin
			v_ff <= 1'h0;
			if (paddr == 12'h054 && pstrb[0]) en_ff <= pwdata[0];
		end else if (rd_acc && paddr == 12'h054) begin
			v_ff <= 1'h1;
			g_ff <= prdata[2];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_calm; !en_ff && !psel; endsequence
	sequence s_flt; en_ff && fault_in && !psel; endsequence
	a_ready_high: assert property (pready) else $error("pready low");
	a_err_map: assert property (acc |-> pslverr == !map) else $error("pslverr wrong");
	a_err_idle: assert property (!acc |-> !pslverr) else $error("pslverr idle");
	a_pol_upper: assert property (rd_acc && paddr == 12'h070 |-> prdata[31:8] == 24'h0)
		else $error("reserved bits set");
	a_guard_inv: assert property (rd_acc && paddr == 12'h074 && v_ff |-> prdata[6] != g_ff)
		else $error("guard status wrong");
	a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved");
	a_chan_follow: assert property (s_calm [*3] |->
		(chan_out ^ $past(chan_out)) == ($past(raw_active) ^ $past(raw_active, 2)))
		else $error("output does not follow");
	a_fault_safe: assert property (s_flt [*6] |-> $stable(chan_out))
		else $error("safe level moved");
endmodule
bind cop_top cop_props i_props(.*);

// File: cop_top.sv
// channel output polarity block with APB register slave
// assumes raw waveforms on pclk and an asynchronous fault pin
//
// Overview of operation
// - polarity bit 0 gives active-high output, 1 gives active-low output.
// - eight polarity bits, channel n at bit n, bits 31-8 reserved.
// - fault control enabled and fault detected forces outputs to inactive state.
// - safe level driven during a fault equals the channel's polarity bit.
// - polarity bits are writable only while write_guard_off in mode equals 1.
// - polarity register sits at offset 70h and resets to all zeros.
// - write_guard_on status always reads as inverse of write_guard_off.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "cop_consts.svh"

module cop_top
	import cop_pkg::*;
(
	input wire logic pclk, // bus clock, 125 MHz
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction, 1 = write
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [3:0] pstrb, // apb byte strobes
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic [7:0] raw_active, // raw channel waveforms, 1 = active
	input wire logic fault_in, // fault pin, 1 = fault, asynchronous
	output logic [7:0] chan_out // channel output pins
);

	// ***********************************
	// state
	// ***********************************
	cop_top_state_t st_ff;
	cop_top_state_t nxt_st;

	logic setup_phase;
	logic access_phase;
	logic wr_access;
	logic hit_mode;
	logic hit_pol;
	logic hit_stat;
	logic hit_any;
	logic guard_on;
	logic safe_all;
	logic [31:0] rd_mux;

	// ***********************************
	// bus decode
	// ***********************************
	assign setup_phase = psel & ~penable;
	assign access_phase = psel & penable;
	assign wr_access = access_phase & pwrite;
	assign hit_mode = (paddr == `COP_MODE_OFFSET);
	assign hit_pol = (paddr == `COP_POL_OFFSET);
	assign hit_stat = (paddr == `COP_STAT_OFFSET);
	assign hit_any = hit_mode | hit_pol | hit_stat;

	// no wait states; only unmapped addresses report an error
	assign pready = 1'b1;
	assign pslverr = access_phase & ~hit_any;
	assign prdata = st_ff.prdata;

	assign guard_on = ~st_ff.guard_off;
	assign safe_all = st_ff.flt_en & st_ff.flt_flag;

	// ***********************************
	// read data
	// ***********************************
	always_comb begin
		rd_mux = 32'h00000000;
		if (hit_pol) begin
			rd_mux[COP_CHANNELS-1:0] = st_ff.pol;
		end else if (hit_mode) begin
			rd_mux[`COP_MODE_FLT_EN_BIT] = st_ff.flt_en;
			rd_mux[`COP_MODE_GUARD_OFF_BIT] = st_ff.guard_off;
		end else if (hit_stat) begin
			rd_mux[`COP_STAT_FLT_IN_BIT] = st_ff.flt_en & st_ff.flt_sync2;
			rd_mux[`COP_STAT_GUARD_ON_BIT] = guard_on;
			rd_mux[`COP_STAT_FLT_FLAG_BIT] = st_ff.flt_flag;
		end
	end

	// ***********************************
	// next state
	// ***********************************
	always_comb begin
		nxt_st = st_ff;

		// two-stage synchroniser for the fault pin
		nxt_st.flt_sync1 = fault_in;
		nxt_st.flt_sync2 = st_ff.flt_sync1;

		// read data captured in setup so it comes from a flop
		if (setup_phase & ~pwrite) begin
			nxt_st.prdata = rd_mux;
		end

		// reading guard_on as 1 arms the unlock
		if (setup_phase & ~pwrite & hit_stat & guard_on) begin
			nxt_st.armed = 1'b1;
		end

		// polarity write, only with the guard off
		if (wr_access & hit_pol & pstrb[0]) begin
			if (st_ff.guard_off) begin
				nxt_st.pol = pwdata[COP_CHANNELS-1:0];
			end
		end

		// mode write
		if (wr_access & hit_mode & pstrb[0]) begin
			nxt_st.flt_en = pwdata[`COP_MODE_FLT_EN_BIT];
			if (pwdata[`COP_MODE_GUARD_OFF_BIT] & st_ff.armed) begin
				nxt_st.guard_off = 1'b1;
			end
			nxt_st.armed = 1'b0;
		end

		// status write: 1 to guard_on relocks, 0 to flag clears if no fault
		if (wr_access & hit_stat & pstrb[0]) begin
			if (pwdata[`COP_STAT_GUARD_ON_BIT]) begin
				nxt_st.guard_off = 1'b0;
				nxt_st.armed = 1'b0;
			end
			if (!pwdata[`COP_STAT_FLT_FLAG_BIT] && !st_ff.flt_sync2) begin
				nxt_st.flt_flag = 1'b0;
			end
		end

		// fault detection; set wins over a clear in the same cycle
		if (st_ff.flt_en & st_ff.flt_sync2) begin
			nxt_st.flt_flag = 1'b1;
		end
	end

	// ***********************************
	// registers
	// ***********************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '{
				pol: `COP_POL_RESET,
				guard_off: `COP_GUARD_OFF_RESET,
				flt_en: `COP_FLT_EN_RESET,
				flt_flag: 1'b0,
				armed: 1'b0,
				flt_sync1: 1'b0,
				flt_sync2: 1'b0,
				prdata: 32'h00000000
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ***********************************
	// channel output stages
	// ***********************************
	for (genvar ch = 0; ch < COP_CHANNELS; ch++) begin : g_chan
		cop_chan_out u_chan (
			.pclk(pclk),
			.presetn(presetn),
			.raw_active(raw_active[ch]),
			.pol(st_ff.pol[ch]),
			.safe(safe_all),
			.chan_out(chan_out[ch])
		);
	end

endmodule
